// File: design/sdc_pkg.sv
package sdc_pkg;

  // Byte offsets in the function's configuration space.
  localparam logic [7:0] OFS_CAP_PTR = 8'h34;
  localparam logic [7:0] OFS_BURST_HINT = 8'h3e;
  localparam logic [7:0] OFS_INTERVAL_HINT = 8'h3f;
  localparam logic [7:0] OFS_SOCKET_INFO = 8'h40;
  localparam logic [7:0] OFS_PM_HEADER = 8'h80;

  // Configuration reads are dword wide; these are the dword indices.
  localparam logic [5:0] DW_CAP_PTR = OFS_CAP_PTR[7:2];
  localparam logic [5:0] DW_HINTS = OFS_BURST_HINT[7:2];
  localparam logic [5:0] DW_SOCKET_INFO = OFS_SOCKET_INFO[7:2];
  localparam logic [5:0] DW_PM_HEADER = OFS_PM_HEADER[7:2];

  // Byte lane of each hint inside the hint dword.
  localparam int BURST_LANE = 2;
  localparam int INTERVAL_LANE = 3;

  // Hint bytes count in units of 0.25 us.
  localparam int HINT_UNIT_NS = 250;
  localparam logic [7:0] BURST_HINT_RST = 8'h07;
  localparam logic [7:0] INTERVAL_HINT_RST = 8'h04;

  // Socket layout byte: reserved bit 7, socket count 6..4, reserved 3, window 2..0.
  localparam int SOCKET_COUNT_LSB = 4;
  localparam int FIRST_WINDOW_LSB = 0;
  localparam logic [2:0] SOCKET_COUNT_ONE = 3'h0;
  localparam logic [2:0] FIRST_WINDOW_ZERO = 3'h0;
  localparam logic [7:0] SOCKET_INFO_VAL = {1'b0, SOCKET_COUNT_ONE, 1'b0, FIRST_WINDOW_ZERO};

  // Capability header: next link in 15..8, kind code in 7..0.
  localparam int NEXT_LINK_LSB = 8;
  localparam int KIND_CODE_LSB = 0;
  localparam logic [7:0] NEXT_LINK_END = 8'h00;
  localparam logic [7:0] CAPABILITY_KIND_CODE_PM = 8'h01;
  localparam logic [15:0] PM_HEADER_VAL = {NEXT_LINK_END, CAPABILITY_KIND_CODE_PM};

  localparam logic [7:0] CAP_PTR_VAL = OFS_PM_HEADER;

endpackage : sdc_pkg

// File: design/sdc_hint_if.sv
`timescale 1ns/100ps
`default_nettype none
interface sdc_hint_if;
  logic [7:0] burst_hint;
  logic [7:0] bus_access_interval_field;
  logic [5:0] dw_sel;
  logic [3:0] byte_en;
  logic [31:0] rdata;

  modport store (output burst_hint, output bus_access_interval_field);
  modport mux (input burst_hint, input bus_access_interval_field, input dw_sel,
               input byte_en, output rdata);
  modport top (input burst_hint, input bus_access_interval_field, input rdata,
               output dw_sel, output byte_en);
endinterface : sdc_hint_if
`default_nettype wire

// File: design/sdc_hint_store.sv
`timescale 1ns/100ps
`default_nettype none
module sdc_hint_store (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ee_load_in,
  input wire logic [7:0] ee_data_in,
  sdc_hint_if.store hint
);

  typedef struct packed {
    logic [7:0] interval;
  } sdc_store_s;

  sdc_store_s cur_ff;
  sdc_store_s nxt_cur;

  // Only reset and the serial EEPROM loader can change the interval hint; host writes never reach here.
  always_comb begin
    nxt_cur = cur_ff;
    if (ee_load_in) begin
      nxt_cur.interval = ee_data_in; // [R5]
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cur_ff.interval <= sdc_pkg::INTERVAL_HINT_RST; // [R3] [R4]
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign hint.bus_access_interval_field = cur_ff.interval;
  assign hint.burst_hint = sdc_pkg::BURST_HINT_RST; // [R1] [R2]

endmodule // sdc_hint_store
`default_nettype wire

// File: design/sdc_read_mux.sv
`timescale 1ns/100ps
`default_nettype none
module sdc_read_mux (
  sdc_hint_if.mux hint
);

  logic [31:0] raw;

  always_comb begin
    raw = 32'h0;
    case (hint.dw_sel)
      sdc_pkg::DW_CAP_PTR: begin
        raw[7:0] = sdc_pkg::CAP_PTR_VAL; // [R13]
      end
      sdc_pkg::DW_HINTS: begin
        raw[8*sdc_pkg::BURST_LANE +: 8] = hint.burst_hint; // [R1]
        raw[8*sdc_pkg::INTERVAL_LANE +: 8] = hint.bus_access_interval_field; // [R3]
      end
      sdc_pkg::DW_SOCKET_INFO: begin
        raw[7:0] = sdc_pkg::SOCKET_INFO_VAL; // [R6] [R7] [R8] [R9]
      end
      sdc_pkg::DW_PM_HEADER: begin
        raw[15:0] = sdc_pkg::PM_HEADER_VAL; // [R10] [R11] [R12]
      end
      default: begin
        raw = 32'h0;
      end
    endcase
  end

  // Lanes the host did not enable read as zero so the answer never leaks stale bytes.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign hint.rdata[8*gi +: 8] = hint.byte_en[gi] ? raw[8*gi +: 8] : 8'h0;
    end
  endgenerate

endmodule // sdc_read_mux
`default_nettype wire

// File: design/sdc_cfg_tail.sv
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// R1 - Burst-grant hint byte at 0x3E resets to 0x07, host cannot write it.
// R2 - Burst-grant default asks for a large latency timer, about 1.75 us bursts.
// R3 - Bus-access-interval hint at 0x3F resets to 0x04, only the device updates it.
// R4 - Interval default asks for very high priority, access every 1 us.
// R5 - EEPROM load sequence may overwrite the interval hint byte.
// R6 - Socket layout byte at 0x40 is read-only and reads 0x00.
// R7 - Socket count field, bits 6 to 4, always reads 000b: one socket.
// R8 - First window field, bits 2 to 0, fixed at 000b: window zero.
// R9 - Bits 7 and 3 of the socket layout byte read zero.
// R10 - Capability header at 0x80 is read-only with value 0x0001.
// R11 - Next capability link, bits 15 to 8, reads 0x00, ending the list.
// R12 - Capability kind code, bits 7 to 0, reads 0x01 for power management.
// R13 - Capabilities pointer byte is fixed at 0x80.
// R14 - Host writes to these bytes complete but change nothing.
module sdc_cfg_tail (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic cfg_req_in,
  input wire logic cfg_wr_in,
  input wire logic [7:0] cfg_addr_in,
  input wire logic [3:0] cfg_be_in,
  input wire logic [31:0] cfg_wdata_in,
  input wire logic ee_load_in,
  input wire logic [7:0] ee_data_in,
  output logic cfg_ack_out,
  output logic cfg_hit_out,
  output logic [31:0] cfg_rdata_out
);

  typedef struct packed {
    logic ack;
    logic hit;
    logic [31:0] rdata;
    logic seen_load;
  } sdc_tail_s;

  sdc_tail_s cur_ff;
  sdc_tail_s nxt_cur;
  logic [5:0] req_dw;
  logic claimed;

  sdc_hint_if hint ();

  sdc_hint_store u_store (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .ee_load_in(ee_load_in),
    .ee_data_in(ee_data_in),
    .hint(hint.store)
  );

  sdc_read_mux u_mux (
    .hint(hint.mux)
  );

  assign req_dw = cfg_addr_in[7:2];
  assign hint.dw_sel = req_dw;
  assign hint.byte_en = cfg_be_in;
  assign claimed = (req_dw == sdc_pkg::DW_CAP_PTR) || (req_dw == sdc_pkg::DW_HINTS) ||
                   (req_dw == sdc_pkg::DW_SOCKET_INFO) || (req_dw == sdc_pkg::DW_PM_HEADER);

  // Every request is answered one cycle later, so back-to-back accesses are fine.
  // Write data is deliberately dropped: all bytes here are read-only to the host.
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.ack = cfg_req_in;
    nxt_cur.hit = cfg_req_in && claimed;
    nxt_cur.rdata = 32'h0;
    if (cfg_req_in && !cfg_wr_in) begin
      nxt_cur.rdata = hint.rdata;
    end
    if (ee_load_in) begin
      nxt_cur.seen_load = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cur_ff.ack <= 1'b0;
      cur_ff.hit <= 1'b0;
      cur_ff.rdata <= 32'h0;
      cur_ff.seen_load <= 1'b0;
    end else begin
      cur_ff <= nxt_cur; // [R14]
    end
  end

  assign cfg_ack_out = cur_ff.ack;
  assign cfg_hit_out = cur_ff.hit;
  assign cfg_rdata_out = cur_ff.rdata;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  logic full_read;
  assign full_read = cfg_req_in && !cfg_wr_in && (cfg_be_in == 4'hf);

  // Decoded views of the live request, shared by the checks below.
  logic read_any;
  logic sel_hints;
  logic sel_socket;
  logic sel_pm;
  logic sel_cap;
  assign read_any = cfg_req_in && !cfg_wr_in;
  assign sel_hints = (req_dw == sdc_pkg::DW_HINTS);
  assign sel_socket = (req_dw == sdc_pkg::DW_SOCKET_INFO);
  assign sel_pm = (req_dw == sdc_pkg::DW_PM_HEADER);
  assign sel_cap = (req_dw == sdc_pkg::DW_CAP_PTR);

  a_burst_hint_read: assert property ( // [R1] [R2]
    full_read && req_dw == sdc_pkg::DW_HINTS |=> cfg_ack_out && cfg_rdata_out[23:16] == 8'h07)
    else $error("burst hint byte did not read 0x07");

  a_interval_default: assert property ( // [R3] [R4]
    !cur_ff.seen_load |-> hint.bus_access_interval_field == 8'h04)
    else $error("interval hint left its default without a load");

  a_interval_load: assert property ( // [R5]
    ee_load_in |=> hint.bus_access_interval_field == $past(ee_data_in))
    else $error("interval hint did not take the loaded value");

  a_interval_hold: assert property ( // [R3] [R14]
    !ee_load_in |=> $stable(hint.bus_access_interval_field))
    else $error("interval hint changed without a load");

  a_interval_read: assert property ( // [R3]
    full_read && req_dw == sdc_pkg::DW_HINTS ##1 !$past(ee_load_in)
    |-> cfg_rdata_out[31:24] == hint.bus_access_interval_field)
    else $error("interval hint read wrong");

  a_socket_info: assert property ( // [R6] [R7] [R8] [R9]
    full_read && req_dw == sdc_pkg::DW_SOCKET_INFO |=> cfg_hit_out && cfg_rdata_out == 32'h0)
    else $error("socket layout byte not zero");

  a_pm_header: assert property ( // [R10] [R11] [R12]
    full_read && req_dw == sdc_pkg::DW_PM_HEADER |=> cfg_hit_out && cfg_rdata_out == 32'h1)
    else $error("capability header not 0x0001");

  a_cap_pointer: assert property ( // [R13]
    full_read && req_dw == sdc_pkg::DW_CAP_PTR |=> cfg_rdata_out == 32'h80)
    else $error("capabilities pointer not 0x80");

  a_write_answer: assert property ( // [R14]
    cfg_req_in && cfg_wr_in |=> cfg_ack_out && cfg_rdata_out == 32'h0)
    else $error("write not completed cleanly");

  a_ack_pulse: assert property (
    !cfg_req_in |=> !cfg_ack_out && !cfg_hit_out)
    else $error("answer without a request");

  // Handshake and claim checks, then per-lane checks: a partial read must still show the right byte and zero elsewhere.
  a_ack_follows_req: assert property ( // [R14]
    cfg_req_in
    |=> cfg_ack_out)
    else $error("request not answered one cycle later");

  a_ack_has_cause: assert property (
    cfg_ack_out
    |-> $past(cfg_req_in))
    else $error("answer without a request one cycle before");

  a_hit_mapped: assert property (
    cfg_req_in && claimed
    |=> cfg_hit_out)
    else $error("mapped request not claimed");

  a_hit_unmapped: assert property (
    cfg_req_in && !claimed
    |=> !cfg_hit_out)
    else $error("unmapped request claimed");

  a_hit_with_ack: assert property (
    cfg_hit_out
    |-> cfg_ack_out)
    else $error("claim shown without an answer");

  a_unmapped_zero: assert property (
    cfg_req_in && !claimed
    |=> cfg_rdata_out == 32'h0)
    else $error("unmapped read returned data");

  a_idle_data_zero: assert property (
    !cfg_req_in
    |=> cfg_rdata_out == 32'h0)
    else $error("read data shown without a request");

  a_data_with_ack: assert property (
    cfg_rdata_out != 32'h0
    |-> cfg_ack_out)
    else $error("read data shown without an answer");

  a_write_keeps_interval: assert property ( // [R14]
    cfg_req_in && cfg_wr_in && !ee_load_in
    |=> $stable(hint.bus_access_interval_field))
    else $error("host write changed the interval hint");

  a_load_seen_flag: assert property ( // [R5]
    ee_load_in
    |=> cur_ff.seen_load)
    else $error("loader pulse not recorded");

  a_burst_lane_value: assert property ( // [R1] [R2]
    read_any && sel_hints && cfg_be_in[2]
    |=> cfg_rdata_out[23:16] == 8'h07)
    else $error("burst hint lane wrong");

  a_burst_lane_mask: assert property ( // [R1]
    read_any && sel_hints && !cfg_be_in[2]
    |=> cfg_rdata_out[23:16] == 8'h00)
    else $error("masked burst hint lane not zero");

  a_interval_lane_value: assert property ( // [R3]
    read_any && sel_hints && cfg_be_in[3] && !ee_load_in
    |=> cfg_rdata_out[31:24] == $past(hint.bus_access_interval_field))
    else $error("interval hint lane wrong");

  a_interval_lane_mask: assert property ( // [R3]
    read_any && sel_hints && !cfg_be_in[3]
    |=> cfg_rdata_out[31:24] == 8'h00)
    else $error("masked interval hint lane not zero");

  a_hint_low_lanes: assert property (
    read_any && sel_hints
    |=> cfg_rdata_out[15:0] == 16'h0)
    else $error("low lanes of the hint word not zero");

  a_load_then_read: assert property ( // [R5]
    ee_load_in ##1 (read_any && sel_hints && cfg_be_in[3])
    |=> cfg_rdata_out[31:24] == $past(ee_data_in, 2))
    else $error("read after a load missed the loaded byte");

  a_burst_const: assert property ( // [R1]
    nrst_in
    |-> hint.burst_hint == 8'h07)
    else $error("burst hint left its fixed value");

  a_socket_bit7: assert property ( // [R9]
    read_any && sel_socket
    |=> !cfg_rdata_out[7])
    else $error("socket layout bit 7 set");

  a_socket_bit3: assert property ( // [R9]
    read_any && sel_socket
    |=> !cfg_rdata_out[3])
    else $error("socket layout bit 3 set");

  a_socket_count: assert property ( // [R7]
    read_any && sel_socket
    |=> cfg_rdata_out[6:4] == 3'h0)
    else $error("socket count field not zero");

  a_socket_window: assert property ( // [R8]
    read_any && sel_socket
    |=> cfg_rdata_out[2:0] == 3'h0)
    else $error("first window field not zero");

  a_socket_upper: assert property ( // [R6]
    read_any && sel_socket
    |=> cfg_rdata_out[31:8] == 24'h0)
    else $error("socket layout word upper lanes not zero");

  a_pm_next_link: assert property ( // [R11]
    read_any && sel_pm && cfg_be_in[1]
    |=> cfg_rdata_out[15:8] == 8'h00)
    else $error("next capability link not zero");

  a_pm_kind_code: assert property ( // [R12]
    read_any && sel_pm && cfg_be_in[0]
    |=> cfg_rdata_out[7:0] == 8'h01)
    else $error("capability kind code not 0x01");

  a_pm_kind_mask: assert property ( // [R12]
    read_any && sel_pm && !cfg_be_in[0]
    |=> cfg_rdata_out[7:0] == 8'h00)
    else $error("masked capability kind lane not zero");

  a_pm_upper: assert property ( // [R10]
    read_any && sel_pm
    |=> cfg_rdata_out[31:16] == 16'h0)
    else $error("capability word upper lanes not zero");

  a_cap_ptr_lane: assert property ( // [R13]
    read_any && sel_cap && cfg_be_in[0]
    |=> cfg_rdata_out[7:0] == 8'h80)
    else $error("capabilities pointer lane wrong");

  a_cap_ptr_upper: assert property ( // [R13]
    read_any && sel_cap
    |=> cfg_rdata_out[31:8] == 24'h0)
    else $error("pointer word upper lanes not zero");

  a_write_no_data: assert property ( // [R14]
    cfg_req_in && cfg_wr_in && claimed
    |=> cfg_hit_out && cfg_rdata_out == 32'h0)
    else $error("mapped write not completed cleanly");

  a_interval_reset: assert property ( // [R3] [R4]
    $rose(nrst_in)
    |-> hint.bus_access_interval_field == 8'h04)
    else $error("interval hint not at default after reset");

  c_hint_read: cover property (full_read && req_dw == sdc_pkg::DW_HINTS ##1 cfg_ack_out);
  c_ee_then_read: cover property (ee_load_in ##[1:4] full_read && req_dw == sdc_pkg::DW_HINTS);
  c_write_hint: cover property (cfg_req_in && cfg_wr_in && req_dw == sdc_pkg::DW_HINTS);
  c_back_to_back: cover property (cfg_req_in ##1 cfg_req_in ##1 cfg_ack_out);

endmodule // sdc_cfg_tail
`default_nettype wire

// File: dv/sdc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module sdc_host_model (
  input wire logic clk_in,
  input wire logic cfg_ack_in,
  input wire logic cfg_hit_in,
  input wire logic [31:0] cfg_rdata_in,
  output logic cfg_req_out,
  output logic cfg_wr_out,
  output logic [7:0] cfg_addr_out,
  output logic [3:0] cfg_be_out,
  output logic [31:0] cfg_wdata_out
);
  initial begin
    cfg_req_out = 1'b0;
    cfg_wr_out = 1'b0;
    cfg_addr_out = 8'h00;
    cfg_be_out = 4'h0;
    cfg_wdata_out = 32'h0000_0000;
  end

  // After the taking edge the qualifiers are inverted, so a design that samples late sees junk.
  task automatic access(input logic wr, input logic [7:0] addr, input logic [3:0] be,
                        input logic [31:0] wdata, output logic hit,
                        output logic [31:0] rdata, output logic lost);
    int i;
    hit = 1'b0;
    rdata = 32'h0000_0000;
    lost = 1'b1;
    @(posedge clk_in);
    cfg_req_out <= 1'b1;
    cfg_wr_out <= wr;
    cfg_addr_out <= addr;
    cfg_be_out <= be;
    cfg_wdata_out <= wdata;
    @(posedge clk_in);
    cfg_req_out <= 1'b0;
    cfg_wr_out <= ~wr;
    cfg_addr_out <= ~addr;
    cfg_be_out <= ~be;
    cfg_wdata_out <= ~wdata;
    for (i = 0; i < 4; i++) begin
      #1;
      if (cfg_ack_in === 1'b1) begin
        hit = cfg_hit_in;
        rdata = cfg_rdata_in;
        lost = 1'b0;
        break;
      end
      @(posedge clk_in);
    end
  endtask
endmodule // sdc_host_model
`default_nettype wire

// File: dv/test_sd_host_config_header_tail.sv
`timescale 1ns/100ps
`default_nettype none
module test_sd_host_config_header_tail;
  logic clk_in, nrst_in, ee_load_in, req, wr, ack, hit, got_hit, lost;
  logic [7:0] ee_data_in, addr;
  logic [3:0] be;
  logic [31:0] wdata, rdata, got_data;
  logic [7:0] ofs [4] = '{8'h34, 8'h3c, 8'h40, 8'h80};
  logic [31:0] expv [4] = '{32'h0000_0080, 32'h0407_0000, 32'h0000_0000, 32'h0000_0001};
  int n_fail, checked, i;

  sdc_cfg_tail sdc_cfg_tail_i (.clk_in(clk_in), .nrst_in(nrst_in), .cfg_req_in(req),
    .cfg_wr_in(wr), .cfg_addr_in(addr), .cfg_be_in(be), .cfg_wdata_in(wdata),
    .ee_load_in(ee_load_in), .ee_data_in(ee_data_in), .cfg_ack_out(ack),
    .cfg_hit_out(hit), .cfg_rdata_out(rdata));
  sdc_host_model sdc_host_model_i (.clk_in(clk_in), .cfg_ack_in(ack), .cfg_hit_in(hit),
    .cfg_rdata_in(rdata), .cfg_req_out(req), .cfg_wr_out(wr), .cfg_addr_out(addr),
    .cfg_be_out(be), .cfg_wdata_out(wdata));

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    if (n_fail == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic go(input logic w, input logic [7:0] a, input logic [3:0] b);
    sdc_host_model_i.access(w, a, b, 32'hffff_ffff, got_hit, got_data, lost);
    if (lost) begin
      n_fail++;
      end_sim();
    end
  endtask

  initial begin
    nrst_in = 1'b0;
    ee_load_in = 1'b0;
    ee_data_in = 8'h00;
    n_fail = 0;
    checked = 0;
    repeat (20) @(posedge clk_in);
    nrst_in <= 1'b1;
    for (i = 0; i < 4; i++) begin
      go(1'b0, ofs[i], 4'hf);
      check(got_data, expv[i]);
      check({31'h0, got_hit}, 32'h1);
    end
    go(1'b0, 8'h3e, 4'h4);
    check(got_data, 32'h0007_0000);
    go(1'b0, 8'h3f, 4'h8);
    check(got_data, 32'h0400_0000);
    go(1'b0, 8'h81, 4'h2);
    check(got_data, 32'h0000_0000);
    go(1'b0, 8'h82, 4'h1);
    check(got_data, 32'h0000_0001);
    go(1'b0, 8'h44, 4'hf);
    check({31'h0, got_hit}, 32'h0);
    check(got_data, 32'h0000_0000);
    for (i = 0; i < 4; i++) begin
      go(1'b1, ofs[i], 4'hf);
      check(got_data, 32'h0000_0000);
    end
    for (i = 0; i < 4; i++) begin
      go(1'b0, ofs[i], 4'hf);
      check(got_data, expv[i]);
    end
    // Loader pulse lasts one clock; data is scrambled after it to catch a late capture.
    @(posedge clk_in);
    ee_load_in <= 1'b1;
    ee_data_in <= 8'h5a;
    @(posedge clk_in);
    ee_load_in <= 1'b0;
    ee_data_in <= 8'ha5;
    go(1'b0, 8'h3c, 4'hc);
    check(got_data, 32'h5a07_0000);
    go(1'b1, 8'h3f, 4'h8);
    go(1'b0, 8'h3c, 4'hc);
    check(got_data, 32'h5a07_0000);
    @(posedge clk_in);
    nrst_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    nrst_in <= 1'b1;
    go(1'b0, 8'h3c, 4'hf);
    check(got_data, 32'h0407_0000);
    end_sim();
  end
endmodule // test_sd_host_config_header_tail
`default_nettype wire
